// [esl_pkg.sv]
package esl_pkg;
    localparam int ESL_MEM_BYTES     = 8192;      // total store
    localparam int ESL_PAGE_BYTES    = 64;
    localparam int ESL_ADDR_W        = 13;
    localparam int ESL_REG_NUM       = 128;       // configuration register count
    // section boundaries (byte addresses)
    localparam logic [12:0] ESL_SEC0_RO_END  = 13'h001F;
    localparam logic [12:0] ESL_SEC1_BASE    = 13'h0040;
    localparam logic [12:0] ESL_SEC1_END     = 13'h00BF;
    localparam logic [12:0] ESL_KEY_BASE     = 13'h1800;
    localparam logic [12:0] ESL_KEY_END      = 13'h1BFF;
    localparam logic [12:0] ESL_PRESET_BASE  = 13'h1C00;
    localparam logic [12:0] ESL_USER_BASE    = 13'h00C0;
    localparam logic [12:0] ESL_USER_END     = 13'h17FF;
    localparam logic [7:0]  ESL_BYTE_RESET   = 8'h00;
    localparam logic [7:0]  ESL_SECTION_RESET_DONE = 8'h00;

    typedef enum logic [4:0] {
        ESL_ST_BOOT = 5'b0_0001,
        ESL_ST_IDLE = 5'b0_0010,
        ESL_ST_COPY = 5'b0_0100,
        ESL_ST_PROG = 5'b0_1000,
        ESL_ST_READ = 5'b1_0000
    } esl_state_t;
endpackage : esl_pkg

// [esl_loader.sv]
`timescale 1ns/1ns
// How it works
// - store is 8 kB, organised as consecutive 64-byte pages.
// - each programming operation writes exactly one whole 64-byte page.
// - five sections: read-only, read/write, free, write-only keys, read-only presets.
// - after reset the register-reset area is copied into configuration registers automatically.
// - preset load command copies a selected preset block into configuration registers.
// - user copy command moves user-stored settings from free section into registers.
// - copies change every register bit: the writable-bit mask is tied to all ones.
module esl_loader
    import esl_pkg::*;
#(
    parameter int REG_NUM = ESL_REG_NUM
) (
    input  wire logic        clk_in,                // 50 MHz system clock
    input  wire logic        sys_rst_in,            // async reset, active high
    input  wire logic        preset_load_in,        // protocol_preset_load command pulse
    input  wire logic [3:0]  preset_sel_in,         // preset block index
    input  wire logic        user_copy_in,          // user_settings_copy command pulse
    input  wire logic [12:0] user_src_in,           // user settings start address
    input  wire logic [6:0]  copy_len_in,           // registers to copy, minus one
    input  wire logic [6:0]  copy_dst_in,           // first destination register
    input  wire logic        page_prog_in,          // page programming request pulse
    input  wire logic [6:0]  page_idx_in,           // page index to program
    input  wire logic [7:0]  page_data_in,          // page fill data for the buffer
    input  wire logic        page_load_in,          // strobe: load page_data into buffer
    input  wire logic [5:0]  page_off_in,           // buffer byte offset
    input  wire logic        rd_req_in,             // read request pulse
    input  wire logic [12:0] rd_addr_in,            // read byte address
    input  wire logic [6:0]  reg_idx_in,            // config register to observe
    output logic [7:0]       rd_data_out,           // read data
    output logic             rd_valid_out,          // read data valid pulse
    output logic             refused_out,           // request refused pulse
    output logic             busy_out,              // copy or programming running
    output logic [7:0]       reg_data_out           // selected config register value
);
    // refuse sizes the 7-bit register index cannot reach
    if (REG_NUM < 1 || REG_NUM > 128) begin : g_reg_num_check
        $error("REG_NUM out of range");
    end

    logic [7:0] mem_r [ESL_MEM_BYTES];
    logic [7:0] page_buf_r [ESL_PAGE_BYTES];
    logic [7:0] cfg_r [REG_NUM];
    logic [7:0] cfg_mask_r [REG_NUM];             // writable-bit mask per register
    esl_state_t state_r;
    logic [12:0] src_r;
    logic [6:0]  dst_r;
    logic [6:0]  cnt_r;
    logic [5:0]  poff_r;
    logic [12:0] pbase_r;
    logic        copy_we;
    logic [12:0] user_last;

    function automatic logic esl_writable(input logic [12:0] a);
        return !(a <= ESL_SEC0_RO_END) && !(a >= ESL_PRESET_BASE);
    endfunction : esl_writable
    function automatic logic esl_readable(input logic [12:0] a);
        return !(a >= ESL_KEY_BASE && a <= ESL_KEY_END);
    endfunction : esl_readable

    // last byte a user copy reads; running past the free area would leak keys into registers
    assign user_last = user_src_in + {6'h00, copy_len_in};

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r      <= ESL_ST_BOOT;
            src_r        <= ESL_SEC1_BASE;
            dst_r        <= 7'h00;
            cnt_r        <= 7'h7F;
            poff_r       <= 6'h00;
            pbase_r      <= 13'h0000;
            rd_valid_out <= 1'b0;
            refused_out  <= 1'b0;
            busy_out     <= 1'b1;
            rd_data_out  <= ESL_BYTE_RESET;
        end else begin
            rd_valid_out <= 1'b0;
            refused_out  <= 1'b0;
            case (state_r)
                ESL_ST_BOOT, ESL_ST_COPY: begin
                    src_r <= src_r + 13'h0001;
                    dst_r <= dst_r + 7'h01;
                    cnt_r <= cnt_r - 7'h01;
                    if (cnt_r == 7'h00) begin
                        state_r  <= ESL_ST_IDLE;
                        busy_out <= 1'b0;
                    end
                end
                ESL_ST_PROG: begin
                    poff_r <= poff_r + 6'h01;
                    if (poff_r == 6'h3F) begin
                        state_r  <= ESL_ST_IDLE;
                        busy_out <= 1'b0;
                    end
                end
                ESL_ST_IDLE: begin
                    if (preset_load_in) begin
                        src_r    <= ESL_PRESET_BASE + {3'b000, preset_sel_in, 6'h00};
                        dst_r    <= copy_dst_in;
                        cnt_r    <= copy_len_in;
                        state_r  <= ESL_ST_COPY;
                        busy_out <= 1'b1;
                    end else if (user_copy_in) begin
                        if (user_src_in >= ESL_USER_BASE && user_last <= ESL_USER_END) begin
                            src_r    <= user_src_in;
                            dst_r    <= copy_dst_in;
                            cnt_r    <= copy_len_in;
                            state_r  <= ESL_ST_COPY;
                            busy_out <= 1'b1;
                        end else begin
                            refused_out <= 1'b1;
                        end
                    end else if (page_prog_in) begin
                        if (esl_writable({page_idx_in, 6'h00})) begin
                            pbase_r  <= {page_idx_in, 6'h00};
                            poff_r   <= 6'h00;
                            state_r  <= ESL_ST_PROG;
                            busy_out <= 1'b1;
                        end else begin
                            refused_out <= 1'b1;
                        end
                    end else if (rd_req_in) begin
                        if (esl_readable(rd_addr_in)) begin
                            rd_data_out  <= mem_r[rd_addr_in];
                            rd_valid_out <= 1'b1;
                        end else begin
                            refused_out <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_r  <= ESL_ST_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // nonvolatile array: no reset, content survives
    always_ff @(posedge clk_in) begin
        if (state_r == ESL_ST_PROG)
            mem_r[pbase_r + {7'h00, poff_r}] <= page_buf_r[poff_r];
    end

    always_ff @(posedge clk_in) begin
        if (page_load_in && state_r != ESL_ST_PROG)
            page_buf_r[page_off_in] <= page_data_in;
    end

    // mask: all bits writable at all times; a tie-off that nothing in this module refines
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < REG_NUM; i++)
            cfg_mask_r[i] <= 8'hFF;
    end

    // no factory image: copying an unprogrammed area loads unknown bytes
    assign copy_we = (state_r == ESL_ST_BOOT) || (state_r == ESL_ST_COPY);
    always_ff @(posedge clk_in) begin
        if (copy_we && int'(dst_r) < REG_NUM)
            cfg_r[dst_r] <= (cfg_r[dst_r] & ~cfg_mask_r[dst_r]) | (mem_r[src_r] & cfg_mask_r[dst_r]);
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            reg_data_out <= ESL_BYTE_RESET;
        else if (int'(reg_idx_in) < REG_NUM)
            reg_data_out <= cfg_r[reg_idx_in];
    end

    a_key_read_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && !user_copy_in && !page_prog_in && rd_req_in
         && rd_addr_in >= ESL_KEY_BASE && rd_addr_in <= ESL_KEY_END) |=> (refused_out && !rd_valid_out))
        else $error("key area read not refused");
    a_page_prog_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_r == ESL_ST_PROG) |-> (state_r == ESL_ST_PROG) [*8])
        else $error("page programming cut short");
    a_boot_copy_end: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_BOOT && cnt_r == 7'h00) |=> (state_r == ESL_ST_IDLE && !busy_out))
        else $error("boot copy did not finish");
    a_ro_prog_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && !user_copy_in && page_prog_in
         && page_idx_in >= 7'h70) |=> (refused_out && state_r == ESL_ST_IDLE))
        else $error("preset page programming not refused");
    a_preset_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && preset_load_in) |=> (state_r == ESL_ST_COPY && src_r >= ESL_PRESET_BASE))
        else $error("preset load did not start");
    a_user_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && user_copy_in && user_src_in >= ESL_USER_BASE
         && user_last <= ESL_USER_END) |=> (state_r == ESL_ST_COPY && src_r == $past(user_src_in)))
        else $error("user copy did not start");
    a_busy_track: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        busy_out == (state_r != ESL_ST_IDLE))
        else $error("busy does not track activity");
    a_copy_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (copy_we && int'(dst_r) < REG_NUM) |=>
        ((cfg_r[$past(dst_r)] & ~$past(cfg_mask_r[dst_r])) == ($past(cfg_r[dst_r]) & ~$past(cfg_mask_r[dst_r]))))
        else $error("protected register bits altered");
    // request priority in idle: preset, user copy, page program, read
    a_user_refuse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && user_copy_in
         && (user_src_in < ESL_USER_BASE || user_last > ESL_USER_END))
        |=> (refused_out && state_r == ESL_ST_IDLE))
        else $error("user copy outside free area not refused");
    a_prog_last_byte: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_PROG && poff_r == 6'h3F) |=> (state_r == ESL_ST_IDLE && !busy_out))
        else $error("page programming overran its page");
    a_prog_one_page: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_PROG) |=> (pbase_r == $past(pbase_r)))
        else $error("page base moved during programming");
    a_read_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && !user_copy_in && !page_prog_in && rd_req_in
         && (rd_addr_in < ESL_KEY_BASE || rd_addr_in > ESL_KEY_END)) |=> (rd_valid_out && !refused_out))
        else $error("readable byte not returned");
    a_key_prog_ok: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && !user_copy_in && page_prog_in
         && page_idx_in >= 7'h60 && page_idx_in <= 7'h6F) |=> (state_r == ESL_ST_PROG && busy_out))
        else $error("key page programming refused");
    a_page0_refuse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == ESL_ST_IDLE && !preset_load_in && !user_copy_in && page_prog_in
         && page_idx_in == 7'h00) |=> (refused_out && state_r == ESL_ST_IDLE))
        else $error("read-only page programming not refused");
endmodule : esl_loader

// [esl_host.sv]
`timescale 1ns/1ns
module esl_host (
    input  wire logic   clk_in,   // clock
    input  wire logic   busy_in,  // busy
    output logic        pre_out,  // preset load
    output logic        usr_out,  // user copy
    output logic [3:0]  sel_out,  // preset index
    output logic [12:0] src_out,  // user source
    output logic [6:0]  len_out,  // count minus one
    output logic [6:0]  dst_out,  // first register
    output logic        prg_out,  // program page
    output logic [6:0]  pg_out,   // page index
    output logic        ld_out,   // buffer strobe
    output logic [5:0]  off_out,  // buffer offset
    output logic [7:0]  dat_out,  // buffer byte
    output logic        rd_out,   // read request
    output logic [12:0] adr_out   // read address
);
    initial {pre_out, usr_out, sel_out, src_out, len_out, dst_out, prg_out, pg_out, ld_out, off_out,
             dat_out, rd_out, adr_out} = '0;
    // callers start 1 ns after an edge; busy requests would be dropped silently
    task automatic idle(output int n);
        for (n = 0; n < 400 && busy_in !== 1'b0; n++) @(posedge clk_in) #1;
    endtask : idle
    // leading edge keeps back-to-back calls from re-raising a strobe in one time step
    task automatic read(input logic [12:0] a);
        @(posedge clk_in) #1;
        {rd_out, adr_out} = {1'b1, a};
        @(posedge clk_in) #1;
        rd_out = 1'b0;
    endtask : read
    // part identity is the byte at 01h alone; 00h and 02h are left unread
    task automatic ident;
        read(13'h0001);
    endtask : ident
    task automatic prog(input logic [6:0] p, input logic [7:0] b);
        for (int i = 0; i < 64; i++) begin
            {ld_out, off_out, dat_out} = {1'b1, i[5:0], b + i[7:0]};
            @(posedge clk_in) #1;
        end
        {ld_out, prg_out, pg_out} = {1'b0, 1'b1, p};
        @(posedge clk_in) #1;
        prg_out = 1'b0;
    endtask : prog
    task automatic copy(input logic u, input logic [3:0] s, input logic [12:0] a, input logic [6:0] d);
        @(posedge clk_in) #1;
        {pre_out, usr_out, sel_out, src_out, len_out, dst_out} = {!u, u, s, a, 7'h03, d};
        @(posedge clk_in) #1;
        {pre_out, usr_out} = 2'b00;
    endtask : copy
endmodule : esl_host

// [test_esl_loader.sv]
`timescale 1ns/1ns
module test_esl_loader;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, preset_load_in, user_copy_in, page_prog_in;
    logic        page_load_in, rd_req_in, rd_valid_out, refused_out, busy_out;
    logic [3:0]  preset_sel_in;
    logic [5:0]  page_off_in;
    logic [6:0]  copy_len_in, copy_dst_in, page_idx_in, reg_idx_in = 7'h00;
    logic [7:0]  page_data_in, rd_data_out, reg_data_out;
    logic [12:0] user_src_in, rd_addr_in;
    int          num_errors = 0, num_checks = 0, cyc = 0, n;
    always #10 clk_in = ~clk_in;
    esl_loader dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .preset_load_in(preset_load_in),
        .preset_sel_in(preset_sel_in), .user_copy_in(user_copy_in), .user_src_in(user_src_in),
        .copy_len_in(copy_len_in), .copy_dst_in(copy_dst_in), .page_prog_in(page_prog_in),
        .page_idx_in(page_idx_in), .page_data_in(page_data_in), .page_load_in(page_load_in),
        .page_off_in(page_off_in), .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .reg_idx_in(reg_idx_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .refused_out(refused_out),
        .busy_out(busy_out), .reg_data_out(reg_data_out));
    esl_host host (.clk_in(clk_in), .busy_in(busy_out), .pre_out(preset_load_in), .usr_out(user_copy_in),
        .sel_out(preset_sel_in), .src_out(user_src_in), .len_out(copy_len_in), .dst_out(copy_dst_in),
        .prg_out(page_prog_in), .pg_out(page_idx_in), .ld_out(page_load_in), .off_out(page_off_in),
        .dat_out(page_data_in), .rd_out(rd_req_in), .adr_out(rd_addr_in));
    task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h got %h", s, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic rd(input logic [12:0] a, input logic v, input logic [7:0] e);
        host.read(a);
        chk("rd_valid", v, rd_valid_out);
        chk("refused", !v, refused_out);
        if (v) chk("rd_data", e, rd_data_out);
    endtask : rd
    task automatic rg(input logic [6:0] i, input logic [7:0] e);
        reg_idx_in = i;
        repeat (2) @(posedge clk_in);
        #1 chk("reg_data", e, reg_data_out);
    endtask : rg
    // reset mid-run too: the store must survive it, registers get reloaded
    task automatic t_boot;
        sys_rst_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        chk("busy", 1, busy_out);
        host.idle(n);
        chk("boot_len", 1, n >= 127 && n <= 130);
    endtask : t_boot
    task automatic t_prog;
        host.prog(7'h01, 8'h10);
        host.idle(n);
        chk("prog_len", 1, n >= 63 && n <= 65);
        host.prog(7'h03, 8'h80);
        host.idle(n);
        rd(13'h0040, 1, 8'h10);
        rd(13'h007F, 1, 8'h4F);
        rd(13'h00FF, 1, 8'hBF);
    endtask : t_prog
    task automatic t_ident;
        host.ident();
        chk("ident_valid", 1, rd_valid_out);
        chk("ident_refused", 0, refused_out);
    endtask : t_ident
    task automatic t_refuse;
        logic [6:0] pg [3] = '{7'h00, 7'h70, 7'h7F};
        for (int i = 0; i < 3; i++) begin
            host.prog(pg[i], 8'h55);
            chk("prog_refused", 1, refused_out);
        end
        host.prog(7'h60, 8'h00);
        chk("key_prog", 0, refused_out);
        host.idle(n);
        rd(13'h1800, 0, 8'h00);
        rd(13'h1BFF, 0, 8'h00);
        host.copy(1'b1, 4'h0, 13'h1800, 7'h00);
        chk("copy_refused", 1, refused_out);
        host.copy(1'b1, 4'h0, 13'h00BF, 7'h00);
        chk("copy_refused", 1, refused_out);
        host.copy(1'b1, 4'h0, 13'h17FE, 7'h00);
        chk("copy_tail_refused", 1, refused_out);
        rd(13'h0040, 1, 8'h10);
    endtask : t_refuse
    task automatic t_copy;
        rg(7'h3F, 8'h4F);
        host.copy(1'b1, 4'h0, 13'h00C0, 7'h05);
        host.idle(n);
        rg(7'h05, 8'h80);
        rg(7'h08, 8'h83);
        rg(7'h09, 8'h19);
        for (int s = 0; s < 16; s++) begin
            host.copy(1'b0, s[3:0], 13'h0000, 7'h70);
            host.idle(n);
            chk("preset_len", 4, n);
        end
        rg(7'h04, 8'h14);
    endtask : t_copy
    initial begin
        t_boot();
        t_prog();
        t_ident();
        t_refuse();
        t_boot();
        t_copy();
        summarize();
    end
endmodule : test_esl_loader
